/* File: poel_params.svh */
// Constants of the operand, output-hold and operation-error logic
`ifndef POEL_PARAMS_SVH
`define POEL_PARAMS_SVH
`define POEL_ADDR_W      8
`define POEL_OFF_CTRL    8'h00
`define POEL_OFF_KEYSET  8'h04
`define POEL_OFF_KEYENT  8'h08
`define POEL_OFF_TADDR   8'h0c
`define POEL_OFF_TDATA   8'h10
`define POEL_OFF_CONST   8'h14
`define POEL_OFF_WORD    8'h18
`define POEL_OFF_BITLO   8'h1c
`define POEL_OFF_BITHI   8'h20
`define POEL_OFF_OPCMD   8'h24
`define POEL_OFF_STEP    8'h28
`define POEL_OFF_ERR     8'h2c
`define POEL_OFF_DIAG    8'h30
`define POEL_CTRL_W      3
`define POEL_CTRL_RST    3'h0
`define POEL_CTRL_RUN    0
`define POEL_CTRL_RESTORE 1
`define POEL_CTRL_ERRSTOP 2
`define POEL_CTRL_SCANEND 3
`define POEL_STAT_RUN    8
`define POEL_STAT_PEND   9
`define POEL_KEY_W       24
`define POEL_KEY_SETB    24
`define POEL_ENT_UNLK    0
`define POEL_ENT_REFU    1
`define POEL_OP_SRC_LO   0
`define POEL_OP_SRC_HI   1
`define POEL_OP_DSTW     2
`define POEL_OP_DIG_LO   3
`define POEL_OP_DIG_HI   5
`define POEL_OP_SOFF_LO  6
`define POEL_OP_SOFF_HI  11
`define POEL_OP_DOFF_LO  12
`define POEL_OP_DOFF_HI  17
`define POEL_ERR_FLAG    0
`define POEL_ERR_CLRSTEP 1
`define POEL_ERR_STEP_LO 16
`define POEL_DIAG_OPERR  16'h0032
`define POEL_WORD_W      16
`define POEL_NBITS       64
`define POEL_BIT_AW      6
`define POEL_YBITS       16
`define POEL_HALF        32
`define POEL_DIG_MAX     3'd4
`define POEL_MEM_AW      6
`define POEL_MEM_DEPTH   64
`endif

/* File: poel_pkg.sv */
// Types shared by the operand and error logic
`default_nettype none
package poel_pkg;
  typedef enum logic [1:0] {POEL_SRC_CONST, POEL_SRC_WORD, POEL_SRC_BITS, POEL_SRC_RSVD} poel_src_t;
  typedef enum logic [1:0] {POEL_STOPPED, POEL_FIRST_SCAN, POEL_RUNNING} poel_run_t;
endpackage : poel_pkg
`default_nettype wire

/* File: poel_mem_if.sv */
// Carrier between the register logic and the stored-content memory
`timescale 1ns/1ps
`default_nettype none
`include "poel_params.svh"
interface poel_mem_if;
  logic                      we;
  logic [`POEL_MEM_AW-1:0]   addr;
  logic [`POEL_WORD_W-1:0]   wdata;
  logic [`POEL_WORD_W-1:0]   rdata;
  modport ctl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface : poel_mem_if
`default_nettype wire

/* File: poel_store_mem.sv */
// Stored parameters, program and comments reached by the tool
`timescale 1ns/1ps
`default_nettype none
`include "poel_params.svh"
module poel_store_mem (
  input wire logic hclk,
  poel_mem_if.mem  port
);
  logic [`POEL_WORD_W-1:0] store [`POEL_MEM_DEPTH];

  always_ff @(posedge hclk) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
    port.rdata <= store[port.addr];
  end
endmodule : poel_store_mem
`default_nettype wire

/* File: poel_top.sv */
// Register slave, operand engine, output hold and operation-error capture
`timescale 1ns/1ps
`default_nettype none
`include "poel_params.svh"
module poel_top
  import poel_pkg::*;
(
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  output logic [`POEL_YBITS-1:0]      y_out,
  output logic                        run_active,
  output logic                        op_error
);
  poel_mem_if mif ();
  poel_store_mem u_mem (.hclk(hclk), .port(mif));

  // Bus: one wait state per transfer so read data can leave a flop
  logic                    bus_pend_reg;
  logic                    bus_wr_reg;
  logic [`POEL_ADDR_W-1:0] bus_addr_reg;
  wire take = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_pend_reg <= 1'b0;
      bus_wr_reg   <= 1'b0;
      bus_addr_reg <= '0;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
    end else begin
      bus_pend_reg <= take;
      hreadyout    <= ~take;
      if (take) begin
        bus_wr_reg   <= hwrite;
        bus_addr_reg <= haddr[`POEL_ADDR_W-1:0];
      end
    end
  end

  wire wr_stb    = bus_pend_reg & bus_wr_reg;
  wire rd_stb    = bus_pend_reg & ~bus_wr_reg;
  wire sel_ctrl  = bus_addr_reg == `POEL_OFF_CTRL;
  wire sel_kset  = bus_addr_reg == `POEL_OFF_KEYSET;
  wire sel_kent  = bus_addr_reg == `POEL_OFF_KEYENT;
  wire sel_taddr = bus_addr_reg == `POEL_OFF_TADDR;
  wire sel_tdata = bus_addr_reg == `POEL_OFF_TDATA;
  wire sel_const = bus_addr_reg == `POEL_OFF_CONST;
  wire sel_word  = bus_addr_reg == `POEL_OFF_WORD;
  wire sel_bitlo = bus_addr_reg == `POEL_OFF_BITLO;
  wire sel_bithi = bus_addr_reg == `POEL_OFF_BITHI;
  wire sel_opcmd = bus_addr_reg == `POEL_OFF_OPCMD;
  wire sel_step  = bus_addr_reg == `POEL_OFF_STEP;
  wire sel_err   = bus_addr_reg == `POEL_OFF_ERR;
  wire sel_diag  = bus_addr_reg == `POEL_OFF_DIAG;

  // Keyword lock
  logic [`POEL_KEY_W-1:0] key_reg;
  logic key_set_reg, unlocked_reg, refused_reg;
  wire locked     = key_set_reg & ~unlocked_reg;
  wire tool_try   = bus_pend_reg & sel_tdata;
  wire tool_refus = tool_try & locked;
  wire wr_kset    = wr_stb & sel_kset & ~locked;
  wire wr_kent    = wr_stb & sel_kent;
  wire key_match  = hwdata[`POEL_KEY_W-1:0] == key_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_reg      <= '0;
      key_set_reg  <= 1'b0;
      unlocked_reg <= 1'b0;
      refused_reg  <= 1'b0;
    end else begin
      if (wr_kset) begin
        key_reg     <= hwdata[`POEL_KEY_W-1:0];
        key_set_reg <= hwdata[`POEL_KEY_SETB];
      end
      if (wr_kset) unlocked_reg <= 1'b0;
      else if (wr_kent) unlocked_reg <= key_set_reg & key_match;
      refused_reg <= tool_refus | (refused_reg & ~wr_kent);
    end
  end

  logic [`POEL_MEM_AW-1:0] taddr_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) taddr_reg <= '0;
    else if (wr_stb & sel_taddr) taddr_reg <= hwdata[`POEL_MEM_AW-1:0];
  end
  assign mif.addr  = taddr_reg;
  assign mif.wdata = hwdata[`POEL_WORD_W-1:0];
  assign mif.we    = wr_stb & sel_tdata & ~locked;

  // Run control
  poel_run_t state_reg, state_next;
  logic [`POEL_CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic run_entry, run_leave;
  logic err_ev;
  wire  stop_err  = err_ev & ctrl_reg[`POEL_CTRL_ERRSTOP];
  wire  scan_end  = wr_stb & sel_ctrl & hwdata[`POEL_CTRL_SCANEND];
  wire  restore   = ctrl_reg[`POEL_CTRL_RESTORE];

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_stb & sel_ctrl) ctrl_next = hwdata[`POEL_CTRL_W-1:0];
    if (stop_err) ctrl_next[`POEL_CTRL_RUN] = 1'b0;
  end

  always_comb begin
    state_next = state_reg;
    run_entry  = 1'b0;
    run_leave  = 1'b0;
    case (state_reg)
      POEL_STOPPED: if (ctrl_reg[`POEL_CTRL_RUN]) begin
        run_entry  = 1'b1;
        state_next = restore ? POEL_RUNNING : POEL_FIRST_SCAN;
      end
      POEL_FIRST_SCAN, POEL_RUNNING: begin
        if (!ctrl_reg[`POEL_CTRL_RUN] || stop_err) begin
          run_leave  = 1'b1;
          state_next = POEL_STOPPED;
        end else if (scan_end) begin
          state_next = POEL_RUNNING;
        end
      end
      default: state_next = POEL_STOPPED;
    endcase
  end

  // Operand engine: dst = dst + src, or a one-point copy
  logic [`POEL_NBITS-1:0] bitdev_reg;
  wire  [`POEL_NBITS-1:0] bitdev_next;
  wire  [`POEL_NBITS-1:0] dmask;
  logic [`POEL_YBITS-1:0] saved_reg;
  logic [`POEL_WORD_W-1:0] const_reg, word_reg, step_reg;
  logic [`POEL_WORD_W-1:0] src_val, mask16;
  wire  [`POEL_WORD_W-1:0] src_bits, dst_bits;

  wire op_stb = wr_stb & sel_opcmd & (state_reg != POEL_STOPPED);
  wire [1:0] op_src    = hwdata[`POEL_OP_SRC_HI:`POEL_OP_SRC_LO];
  wire       op_dstw   = hwdata[`POEL_OP_DSTW];
  wire [2:0] op_dig    = hwdata[`POEL_OP_DIG_HI:`POEL_OP_DIG_LO];
  wire [`POEL_BIT_AW-1:0] src_off = hwdata[`POEL_OP_SOFF_HI:`POEL_OP_SOFF_LO];
  wire [`POEL_BIT_AW-1:0] dst_off = hwdata[`POEL_OP_DOFF_HI:`POEL_OP_DOFF_LO];
  wire       op_ok     = op_dig <= `POEL_DIG_MAX;
  wire       op_single = op_dig == 3'h0;
  wire [4:0] grp_width = {op_dig[2:0], 2'b00};

  always_comb begin
    mask16 = (op_dig >= `POEL_DIG_MAX) ? 16'hffff : 16'((16'h0001 << grp_width) - 16'h0001);
    case (poel_src_t'(op_src))
      POEL_SRC_CONST: src_val = const_reg;
      POEL_SRC_WORD:  src_val = word_reg;
      POEL_SRC_BITS:  src_val = src_bits & mask16;
      default:        src_val = 16'h0000;
    endcase
  end

  // Prior destination contents enter the sum
  wire [`POEL_WORD_W-1:0] dst_old = op_dstw ? word_reg : (dst_bits & mask16);
  // Sign-extended add flags signed overflow as the instruction's error
  wire [`POEL_WORD_W:0] sum17 = {dst_old[`POEL_WORD_W-1], dst_old}
                              + {src_val[`POEL_WORD_W-1], src_val};
  wire [`POEL_WORD_W-1:0] op_result = sum17[`POEL_WORD_W-1:0];
  wire ovf = sum17[`POEL_WORD_W] ^ sum17[`POEL_WORD_W-1];
  wire single_bit = (poel_src_t'(op_src) == POEL_SRC_BITS) ? src_bits[0] : src_val[0];
  wire bit_op  = op_stb & op_ok & (op_single | ~op_dstw);
  wire word_op = op_stb & op_ok & ~op_single & op_dstw;
  assign err_ev = op_stb & op_ok & ~op_single & ovf;
  wire wr_bitlo = wr_stb & sel_bitlo;
  wire wr_bithi = wr_stb & sel_bithi;

  // Offsets add modulo the area size, so a long group spills into the next points
  for (genvar i = 0; i < `POEL_WORD_W; i++) begin : g_grp
    assign src_bits[i] = bitdev_reg[6'(i) + src_off];
    assign dst_bits[i] = bitdev_reg[6'(i) + dst_off];
  end

  for (genvar j = 0; j < `POEL_NBITS; j++) begin : g_bit
    wire [`POEL_BIT_AW-1:0] rel = 6'(j) - dst_off;
    wire in_grp = op_single ? (rel == 6'h00) : ({1'b0, grp_width} > rel);
    wire op_bit = op_single ? single_bit : op_result[rel[3:0]];
    wire sw_bit;
    wire after_op;
    assign dmask[j] = bit_op & in_grp;
    if (j < `POEL_HALF) begin : g_lo
      assign sw_bit = wr_bitlo ? hwdata[j] : bitdev_reg[j];
    end else begin : g_hi
      assign sw_bit = wr_bithi ? hwdata[j-`POEL_HALF] : bitdev_reg[j];
    end
    assign after_op = dmask[j] ? op_bit : sw_bit;
    if (j < `POEL_YBITS) begin : g_y
      assign bitdev_next[j] = run_entry ? (restore & saved_reg[j]) : after_op;
    end else begin : g_m
      assign bitdev_next[j] = after_op;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg  <= POEL_STOPPED;
      ctrl_reg   <= `POEL_CTRL_RST;
      bitdev_reg <= '0;
      saved_reg  <= '0;
      y_out      <= '0;
      run_active <= 1'b0;
    end else begin
      state_reg  <= state_next;
      ctrl_reg   <= ctrl_next;
      bitdev_reg <= bitdev_next;
      if (run_leave) saved_reg <= bitdev_reg[`POEL_YBITS-1:0];
      // Outputs stay off while stopped and through the first scan in clear mode
      y_out      <= (state_next == POEL_RUNNING) ? bitdev_next[`POEL_YBITS-1:0] : '0;
      run_active <= state_next != POEL_STOPPED;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      const_reg <= '0;
      word_reg  <= '0;
      step_reg  <= '0;
    end else begin
      if (wr_stb & sel_const & (state_reg == POEL_STOPPED)) begin
        const_reg <= hwdata[`POEL_WORD_W-1:0];
      end
      if (word_op) word_reg <= op_result;
      else if (wr_stb & sel_word) word_reg <= hwdata[`POEL_WORD_W-1:0];
      if (wr_stb & sel_step) step_reg <= hwdata[`POEL_WORD_W-1:0];
    end
  end

  // Operation error capture; a new error beats a flag clear in the same cycle
  logic [`POEL_WORD_W-1:0] err_step_reg, diag_reg;
  wire clr_flag = wr_stb & sel_err & hwdata[`POEL_ERR_FLAG];
  wire clr_step = wr_stb & sel_err & hwdata[`POEL_ERR_CLRSTEP];
  wire capture  = err_ev & (~op_error | clr_flag);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_error     <= 1'b0;
      err_step_reg <= '0;
      diag_reg     <= '0;
    end else begin
      op_error <= err_ev | (op_error & ~clr_flag);
      if (capture) err_step_reg <= step_reg;
      else if (clr_step) err_step_reg <= '0;
      if (err_ev) diag_reg <= `POEL_DIAG_OPERR;
      else if (wr_stb & sel_diag) diag_reg <= '0;
    end
  end

  wire [31:0] ctrl_rd = {22'h0, state_reg == POEL_FIRST_SCAN, state_reg != POEL_STOPPED,
                         5'h00, ctrl_reg};
  wire [31:0] rd_mux =
      sel_ctrl  ? ctrl_rd :
      sel_kset  ? {7'h00, key_set_reg, 24'h000000} :
      sel_kent  ? {30'h0, refused_reg, unlocked_reg} :
      sel_taddr ? {26'h0, taddr_reg} :
      sel_tdata ? (locked ? 32'h0 : {16'h0, mif.rdata}) :
      sel_const ? {16'h0, const_reg} :
      sel_word  ? {16'h0, word_reg} :
      sel_bitlo ? bitdev_reg[`POEL_HALF-1:0] :
      sel_bithi ? bitdev_reg[`POEL_NBITS-1:`POEL_HALF] :
      sel_step  ? {16'h0, step_reg} :
      sel_err   ? {err_step_reg, 15'h0, op_error} :
      sel_diag  ? {16'h0, diag_reg} : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= '0;
    else if (rd_stb) hrdata <= rd_mux;
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_first_err;
    err_ev && !op_error && !clr_flag;
  endsequence
  sequence s_enter_restore;
    state_reg == POEL_STOPPED && run_entry && restore;
  endsequence

  AST_BUS_WAIT: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("bus wait state missing");
  AST_LOCK_READ: assert property (rd_stb && sel_tdata && locked |=> hrdata == 32'h0)
    else $error("locked tool read returned data");
  // The stored word must read back unchanged two edges after a refused write
  AST_LOCK_WRITE: assert property (wr_stb && sel_tdata && locked |=> ##1 $stable(mif.rdata))
    else $error("locked tool write reached store");
  AST_SAVE_STOP: assert property (run_leave |=>
      saved_reg == $past(bitdev_reg[`POEL_YBITS-1:0]))
    else $error("outputs not saved on stop");
  AST_RESTORE: assert property (s_enter_restore |=> y_out == $past(saved_reg))
    else $error("saved outputs not restored");
  AST_CLEAR_SCAN: assert property (state_reg == POEL_FIRST_SCAN |-> y_out == 16'h0000)
    else $error("outputs driven before first scan ended");
  AST_SINGLE: assert property (bit_op && op_single |=>
      $countones(bitdev_reg ^ $past(bitdev_reg)) <= 1)
    else $error("single-bit op touched several points");
  AST_DST_MASK: assert property (bit_op && !op_single |=>
      ((bitdev_reg ^ $past(bitdev_reg)) & ~$past(dmask)) == 64'h0)
    else $error("points outside group changed");
  AST_ERR_CAPT: assert property (s_first_err |=> op_error && err_step_reg == $past(step_reg))
    else $error("error step not captured");
  AST_ERR_HOLD: assert property (op_error && !clr_flag && !clr_step |=> $stable(err_step_reg))
    else $error("error step changed while flag set");
  AST_ERR_STOP: assert property (stop_err && state_reg != POEL_STOPPED |=>
      state_reg == POEL_STOPPED ##1 state_reg == POEL_STOPPED)
    else $error("no stop on operation error");
  AST_DIAG: assert property (err_ev |=> diag_reg == `POEL_DIAG_OPERR)
    else $error("error number not stored");
  AST_CONST: assert property (state_reg != POEL_STOPPED |=> $stable(const_reg))
    else $error("constant changed while running");
endmodule : poel_top
`default_nettype wire

/* File: poel_tool_model.sv */
// Programming-tool model: single-word AHB-Lite master that reaches the registers
`timescale 1ns/1ps
`default_nettype none
module poel_tool_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  output logic             timed_out
);
  initial begin
    hsel      = 1'b0;
    haddr     = 32'h0;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hsize     = 3'h2;
    hwdata    = 32'h0;
    timed_out = 1'b0;
  end

  // Bounded wait for hready at a rising edge; a lost answer raises timed_out
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) timed_out <= 1'b1;
  endtask : wait_rdy

  // Entered just after a rising edge; each phase holds until hready is seen
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    // Released data lines show a changed pattern, never a stale copy
    hwdata <= ~d;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
endmodule : poel_tool_model
`default_nettype wire

/* File: tb_plc_operand_and_error_logic.sv */
// Self-checking bench for the operand, output-hold and operation-error block
`timescale 1ns/1ps
`default_nettype none
`include "poel_params.svh"
module tb_plc_operand_and_error_logic;
  logic        hclk = 1'b0;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [15:0] y_out;
  logic        run_active;
  logic        op_error;
  logic        timed_out;
  int          n_fail;
  int          n_tests;

  always #2 hclk = ~hclk;

  poel_top i_poel_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .y_out(y_out),
    .run_active(run_active), .op_error(op_error)
  );

  poel_tool_model i_poel_tool_model (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .timed_out(timed_out)
  );

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] got;
    i_poel_tool_model.xfer(1'b0, a, 32'h0, got);
    chk($sformatf("reg_%h", a), exp, got);
  endtask : chk_reg

  // Samples once the edge's updates have landed, then realigns to a rising edge
  task automatic ports(input logic [15:0] y, input logic ra, input logic oe);
    #1;
    chk("y_out", {16'h0, y}, {16'h0, y_out});
    chk("run_active", {31'h0, ra}, {31'h0, run_active});
    chk("op_error", {31'h0, oe}, {31'h0, op_error});
    chk("hresp", 32'h0, {31'h0, hresp});
    @(posedge hclk);
  endtask : ports

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_poel_tool_model.wr(a, d);
  endtask : wr

  function automatic logic [31:0] op(input logic [1:0] src, input logic dw,
    input logic [2:0] dig, input logic [5:0] so, input logic [5:0] dof);
    op = {14'h0, dof, so, dig, dw, src};
  endfunction : op

  always @(posedge hclk) begin
    if (timed_out === 1'b1) begin
      n_fail++;
      stop_test();
    end
  end

  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    stop_test();
  end

  initial begin
    hresetn = 1'b0;
    n_fail  = 0;
    n_tests = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    ports(16'h0, 1'b0, 1'b0);
    wr(8'h40, 32'hffff_ffff);
    chk_reg(8'h40, 32'h0);
    wr(`POEL_OFF_TADDR, 32'h5);
    chk_reg(`POEL_OFF_TADDR, 32'h5);
    wr(`POEL_OFF_TDATA, 32'h1234);
    wr(`POEL_OFF_KEYSET, 32'h01ab_cdef);
    chk_reg(`POEL_OFF_KEYSET, 32'h0100_0000);
    wr(`POEL_OFF_TDATA, 32'h5555);
    chk_reg(`POEL_OFF_TDATA, 32'h0);
    chk_reg(`POEL_OFF_KEYENT, 32'h2);
    wr(`POEL_OFF_KEYENT, 32'h00ab_cdee);
    chk_reg(`POEL_OFF_KEYENT, 32'h0);
    wr(`POEL_OFF_KEYSET, 32'h0);
    chk_reg(`POEL_OFF_KEYSET, 32'h0100_0000);
    wr(`POEL_OFF_KEYENT, 32'h00ab_cdef);
    chk_reg(`POEL_OFF_KEYENT, 32'h1);
    chk_reg(`POEL_OFF_TDATA, 32'h1234);
    wr(`POEL_OFF_KEYSET, 32'h0);
    chk_reg(`POEL_OFF_KEYSET, 32'h0);
    wr(`POEL_OFF_CONST, 32'h3);
    wr(`POEL_OFF_BITLO, 32'h1234_a5a5);
    wr(`POEL_OFF_BITHI, 32'hc000_fedc);
    wr(`POEL_OFF_CTRL, 32'h1);
    ports(16'h0, 1'b1, 1'b0);
    chk_reg(`POEL_OFF_CTRL, 32'h301);
    chk_reg(`POEL_OFF_BITLO, 32'h1234_0000);
    wr(`POEL_OFF_BITLO, 32'h1234_00f0);
    ports(16'h0, 1'b1, 1'b0);
    wr(`POEL_OFF_CTRL, 32'h9);
    ports(16'h00f0, 1'b1, 1'b0);
    wr(`POEL_OFF_CTRL, 32'h0);
    ports(16'h0, 1'b0, 1'b0);
    // Scribble the points while stopped so only the saved copy can restore them
    wr(`POEL_OFF_BITLO, 32'h1234_0000);
    wr(`POEL_OFF_CTRL, 32'h3);
    ports(16'h00f0, 1'b1, 1'b0);
    chk_reg(`POEL_OFF_CTRL, 32'h103);
    wr(`POEL_OFF_BITLO, 32'h1234_00f0);
    wr(`POEL_OFF_CONST, 32'h9);
    chk_reg(`POEL_OFF_CONST, 32'h3);
    wr(`POEL_OFF_WORD, 32'h000a);
    wr(`POEL_OFF_OPCMD, op(2'd0, 1'b1, 3'd4, 6'd0, 6'd0));
    chk_reg(`POEL_OFF_WORD, 32'h000d);
    wr(`POEL_OFF_OPCMD, op(2'd1, 1'b1, 3'd4, 6'd0, 6'd0));
    chk_reg(`POEL_OFF_WORD, 32'h001a);
    for (int d = 1; d <= 4; d++) begin
      wr(`POEL_OFF_WORD, 32'h0);
      wr(`POEL_OFF_OPCMD, op(2'd2, 1'b1, d[2:0], 6'd32, 6'd0));
      chk_reg(`POEL_OFF_WORD, {16'h0, 16'hfedc & ~(16'hffff << (4 * d))});
    end
    // Three groups read positive, four read negative: only the latter overflows
    wr(`POEL_OFF_WORD, 32'h8000);
    wr(`POEL_OFF_OPCMD, op(2'd2, 1'b1, 3'd3, 6'd32, 6'd0));
    ports(16'h00f0, 1'b1, 1'b0);
    chk_reg(`POEL_OFF_WORD, 32'h8edc);
    wr(`POEL_OFF_STEP, 32'hffff_8001);
    chk_reg(`POEL_OFF_STEP, 32'h8001);
    wr(`POEL_OFF_WORD, 32'h8000);
    wr(`POEL_OFF_OPCMD, op(2'd2, 1'b1, 3'd4, 6'd32, 6'd0));
    ports(16'h00f0, 1'b1, 1'b1);
    chk_reg(`POEL_OFF_ERR, 32'h8001_0001);
    chk_reg(`POEL_OFF_DIAG, 32'h0000_0032);
    wr(`POEL_OFF_DIAG, 32'h0);
    chk_reg(`POEL_OFF_DIAG, 32'h0);
    chk_reg(`POEL_OFF_WORD, 32'h7edc);
    wr(`POEL_OFF_STEP, 32'h0456);
    wr(`POEL_OFF_WORD, 32'h7fff);
    wr(`POEL_OFF_OPCMD, op(2'd0, 1'b1, 3'd4, 6'd0, 6'd0));
    chk_reg(`POEL_OFF_ERR, 32'h8001_0001);
    wr(`POEL_OFF_ERR, 32'h3);
    chk_reg(`POEL_OFF_ERR, 32'h0);
    wr(`POEL_OFF_WORD, 32'h7ffc);
    wr(`POEL_OFF_OPCMD, op(2'd0, 1'b1, 3'd4, 6'd0, 6'd0));
    ports(16'h00f0, 1'b1, 1'b0);
    wr(`POEL_OFF_WORD, 32'hffff);
    wr(`POEL_OFF_OPCMD, op(2'd0, 1'b1, 3'd4, 6'd0, 6'd0));
    chk_reg(`POEL_OFF_WORD, 32'h0002);
    // Source code 3 adds nothing, so the word keeps its prior contents
    wr(`POEL_OFF_OPCMD, op(2'd3, 1'b1, 3'd4, 6'd0, 6'd0));
    chk_reg(`POEL_OFF_WORD, 32'h0002);
    wr(`POEL_OFF_OPCMD, op(2'd0, 1'b0, 3'd1, 6'd0, 6'd36));
    chk_reg(`POEL_OFF_BITHI, 32'hc000_fe0c);
    wr(`POEL_OFF_OPCMD, op(2'd2, 1'b0, 3'd0, 6'd34, 6'd40));
    chk_reg(`POEL_OFF_BITHI, 32'hc000_ff0c);
    wr(`POEL_OFF_OPCMD, op(2'd0, 1'b0, 3'd1, 6'd0, 6'd62));
    wr(`POEL_OFF_OPCMD, op(2'd0, 1'b0, 3'd5, 6'd0, 6'd36));
    chk_reg(`POEL_OFF_BITHI, 32'h8000_ff0c);
    chk_reg(`POEL_OFF_BITLO, 32'h1234_00f1);
    ports(16'h00f1, 1'b1, 1'b0);
    wr(`POEL_OFF_CTRL, 32'h7);
    wr(`POEL_OFF_WORD, 32'h7fff);
    wr(`POEL_OFF_OPCMD, op(2'd0, 1'b1, 3'd4, 6'd0, 6'd0));
    ports(16'h0, 1'b0, 1'b1);
    chk_reg(`POEL_OFF_CTRL, 32'h6);
    stop_test();
  end
endmodule : tb_plc_operand_and_error_logic
`default_nettype wire
